/* include/scc_pkg.sv */
package scc_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int          SCC_ADDR_W        = 8;
    localparam int          SCC_DATA_W        = 32;
    localparam int          SCC_BE_W          = 4;
    localparam int          SCC_WORD_LSB      = 2;
    localparam logic [7:0]  SCC_CFG_OFS       = 8'h58;
    localparam logic [31:0] SCC_CFG_RST       = 32'h0011_0001;
    // writable bits; everything else reads as zero
    localparam logic [31:0] SCC_CFG_RW_MASK   = 32'hf111_1011;
    localparam logic [31:0] SCC_CFG_RO_MASK   = 32'h0eee_efee;
    localparam logic [31:0] SCC_ZERO          = 32'h0000_0000;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int          SCC_SPARE_LSB     = 28;
    localparam int          SCC_SPARE_MSB     = 31;
    localparam int          SCC_CLASS_B_BIT   = 24;
    localparam int          SCC_CLASS_A_BIT   = 20;
    localparam int          SCC_PAY_IF_BIT    = 16;
    localparam int          SCC_AUX_EN_BIT    = 12;
    localparam int          SCC_WAKE_EN_BIT   = 4;
    localparam int          SCC_SOCK_EN_BIT   = 0;
    localparam int          SCC_BYTE_W        = 8;

    // ---------------------------------------------------------------
    // socket side
    // ---------------------------------------------------------------
    localparam int          SCC_AUX_PINS      = 2;

endpackage

/* hdl/scc_pin_sync.sv */
// three-stage synchroniser for one pin; a change is taken only once
// the second and third stages agree, which also rejects one-cycle glitches
module scc_pin_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // ---------------------------------------------------------------
    // stage chain
    // ---------------------------------------------------------------
    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // filtered level moves only on agreement
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_q <= 1'b0;
        end else if (ce_i && (s2_q == s3_q)) begin
            level_q <= s3_q;
        end
    end

    assign level_o = level_q;
    assign rise_o  = (s2_q == s3_q) && s3_q && !level_q;

endmodule // scc_pin_sync

/* hdl/scc_socket_cfg.sv */
// Overview of operation
// - The whole register loads its reset value only from the global reset, no other reset.
// - Read-only reserved groups 27:25, 23:21, 19:17, 15:13, 11:5, 3:1 read zero, writes ignored.
// - Bit 24 is writable, declares Class B card support for socket 0, resets to zero.
// - Bit 20 is writable, declares Class A card support for socket 0, resets to one.
// - The payment card interface of socket 0 is enabled only while bit 16 is one, reset one.
// - The auxiliary card pins of socket 0 are enabled only while bit 12 is one, reset zero.
// - With bit 4 set each card insertion outside functional reset raises a wake event; with it clear none is raised.
// - Socket 0 operates only while bit 0 is one, which resets to one.
module scc_socket_cfg #(
    parameter int AUX_W = scc_pkg::SCC_AUX_PINS
) (
    input  wire logic                          clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          ce_i,
    input  wire logic                          func_rst_n_i,
    input  wire logic                          cfg_rd_i,
    input  wire logic                          cfg_wr_i,
    input  wire logic [scc_pkg::SCC_ADDR_W-1:0] cfg_addr_i,
    input  wire logic [scc_pkg::SCC_BE_W-1:0]   cfg_be_i,
    input  wire logic [scc_pkg::SCC_DATA_W-1:0] cfg_wdata_i,
    output logic      [scc_pkg::SCC_DATA_W-1:0] cfg_rdata_o,
    output logic                               cfg_rvalid_o,
    output logic                               sock0_enable_o,
    output logic                               sock0_volt_class_a_support_o,
    output logic                               sock0_volt_class_b_support_o,
    output logic                               sock0_payment_if_enable_o,
    output logic                               sock0_insert_wake_enable_o,
    input  wire logic                          card_present_i,
    output logic                               pme_event_o,
    input  wire logic [AUX_W-1:0]              core_aux_out_i,
    input  wire logic [AUX_W-1:0]              core_aux_oe_i,
    output logic      [AUX_W-1:0]              core_aux_in_o,
    input  wire logic [AUX_W-1:0]              card_aux_pins_i,
    output logic      [AUX_W-1:0]              card_aux_pins_o,
    output logic      [AUX_W-1:0]              card_aux_pins_oe_o
);

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // dword hit; low two address bits are ignored, cfg_be_i picks lanes
    function automatic logic scc_hit(input logic [scc_pkg::SCC_ADDR_W-1:0] a);
        scc_hit = (a[scc_pkg::SCC_ADDR_W-1:scc_pkg::SCC_WORD_LSB] ==
                   scc_pkg::SCC_CFG_OFS[scc_pkg::SCC_ADDR_W-1:scc_pkg::SCC_WORD_LSB]);
    endfunction

    // byte-lane merge of write data into the old value
    function automatic logic [31:0] scc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < scc_pkg::SCC_BE_W; b++) begin
            if (be[b]) begin
                r[b*scc_pkg::SCC_BYTE_W +: scc_pkg::SCC_BYTE_W] =
                    new_v[b*scc_pkg::SCC_BYTE_W +: scc_pkg::SCC_BYTE_W];
            end
        end
        scc_merge = r;
    endfunction

    logic [31:0]      cfg_q;
    logic [31:0]      cfg_d;
    logic             wr_hit;
    logic             rd_hit;
    logic             ins_rise;
    logic [AUX_W-1:0] aux_level;
    logic             aux_live;
    logic             seen_q;

    assign wr_hit = cfg_wr_i && scc_hit(cfg_addr_i);
    assign rd_hit = cfg_rd_i && scc_hit(cfg_addr_i);

    // ---------------------------------------------------------------
    // configuration register
    // ---------------------------------------------------------------
    // reserved read-only bits are masked away, so they never store
    assign cfg_d = scc_merge(cfg_q, cfg_wdata_i, cfg_be_i) & scc_pkg::SCC_CFG_RW_MASK;

    // only the global reset reaches this flop; the functional reset
    // deliberately does not, so a socket reset keeps software's setup
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_q <= scc_pkg::SCC_CFG_RST;
        end else if (ce_i && wr_hit) begin
            cfg_q <= cfg_d;
        end
    end

    // read data is registered; unmapped dwords read zero
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_rdata_o  <= scc_pkg::SCC_ZERO;
            cfg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                cfg_rdata_o <= rd_hit ? (cfg_q & scc_pkg::SCC_CFG_RW_MASK)
                                      : scc_pkg::SCC_ZERO;
            end
        end
    end

    // ---------------------------------------------------------------
    // configuration outputs
    // ---------------------------------------------------------------
    assign sock0_enable_o               = cfg_q[scc_pkg::SCC_SOCK_EN_BIT];
    assign sock0_volt_class_a_support_o = cfg_q[scc_pkg::SCC_CLASS_A_BIT];
    assign sock0_volt_class_b_support_o = cfg_q[scc_pkg::SCC_CLASS_B_BIT];
    assign sock0_payment_if_enable_o    = cfg_q[scc_pkg::SCC_PAY_IF_BIT];
    assign sock0_insert_wake_enable_o   = cfg_q[scc_pkg::SCC_WAKE_EN_BIT];
    // aux pins need both the pin enable and the socket enable
    assign aux_live = cfg_q[scc_pkg::SCC_AUX_EN_BIT] &&
                      cfg_q[scc_pkg::SCC_SOCK_EN_BIT];

    // ---------------------------------------------------------------
    // card insertion wake event
    // ---------------------------------------------------------------
    scc_pin_sync u_ins_sync (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .pin_i   (card_present_i),
        .level_o (),
        .rise_o  (ins_rise)
    );

    // one-cycle pulse per filtered insertion edge
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pme_event_o <= 1'b0;
        end else if (ce_i) begin
            if (!func_rst_n_i) begin
                pme_event_o <= 1'b0;
            end else begin
                pme_event_o <= ins_rise && cfg_q[scc_pkg::SCC_WAKE_EN_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // auxiliary card pins
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < AUX_W; gi++) begin : g_aux_sync
            scc_pin_sync u_aux_sync (
                .clk_i   (clk_i),
                .nrst_i  (nrst_i),
                .ce_i    (ce_i),
                .pin_i   (card_aux_pins_i[gi]),
                .level_o (aux_level[gi]),
                .rise_o  ()
            );
        end
    endgenerate

    // pins released and inputs forced low whenever the pins are off;
    // costs one cycle of latency but keeps pin outputs glitch free
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            card_aux_pins_o    <= '0;
            card_aux_pins_oe_o <= '0;
            core_aux_in_o      <= '0;
        end else if (ce_i) begin
            if (!func_rst_n_i || !aux_live) begin
                card_aux_pins_o    <= '0;
                card_aux_pins_oe_o <= '0;
                core_aux_in_o      <= '0;
            end else begin
                card_aux_pins_o    <= core_aux_out_i;
                card_aux_pins_oe_o <= core_aux_oe_i;
                core_aux_in_o      <= aux_level;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // marks that the first enabled edge after reset has passed
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seen_q <= 1'b0;
        end else if (ce_i) begin
            seen_q <= 1'b1;
        end
    end

    a_reset_value: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !seen_q |-> (cfg_q == scc_pkg::SCC_CFG_RST))
        else $error("config register not at reset value after reset");

    a_hold_no_write: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !(ce_i && wr_hit) |=> $stable(cfg_q))
        else $error("config register changed without a write");

    a_reserved_zero: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cfg_rvalid_o |-> ((cfg_rdata_o & scc_pkg::SCC_CFG_RO_MASK) == scc_pkg::SCC_ZERO))
        else $error("reserved read-only bits read non-zero");

    a_class_b_write: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && wr_hit && cfg_be_i[3])
        |=> (sock0_volt_class_b_support_o == $past(cfg_wdata_i[scc_pkg::SCC_CLASS_B_BIT])))
        else $error("class b bit did not take written value");

    a_class_a_write: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && wr_hit && cfg_be_i[2])
        |=> (sock0_volt_class_a_support_o == $past(cfg_wdata_i[scc_pkg::SCC_CLASS_A_BIT])))
        else $error("class a bit did not take written value");

    a_pay_if_read: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && rd_hit && !cfg_wr_i)
        |=> (cfg_rdata_o[scc_pkg::SCC_PAY_IF_BIT] == sock0_payment_if_enable_o))
        else $error("payment interface enable differs from readback");

    // judged one edge after an enabled edge that sees the enable clear, so a frozen
    // clock enable between the write and the check cannot trip it
    a_aux_needs_en: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && !cfg_q[scc_pkg::SCC_AUX_EN_BIT])
        |=> (card_aux_pins_oe_o == '0) && (card_aux_pins_o == '0) && (core_aux_in_o == '0))
        else $error("aux pins driven while aux enable is clear");

    a_wake_event: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && func_rst_n_i && ins_rise)
        |=> (pme_event_o == $past(cfg_q[scc_pkg::SCC_WAKE_EN_BIT])))
        else $error("wake event does not follow insertion and enable");

    a_sock_gates_aux: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && !sock0_enable_o) |=> (card_aux_pins_oe_o == '0) && (core_aux_in_o == '0))
        else $error("aux pins active while socket disabled");

    // write, one cycle with no write taken, then a read of the register
    a_spare_store: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && wr_hit && cfg_be_i[3]) ##1 !(ce_i && wr_hit) ##1 (ce_i && rd_hit)
        |=> (cfg_rdata_o[scc_pkg::SCC_SPARE_MSB:scc_pkg::SCC_SPARE_LSB] ==
             $past(cfg_wdata_i[scc_pkg::SCC_SPARE_MSB:scc_pkg::SCC_SPARE_LSB], 3)))
        else $error("spare bits did not read back written value");

endmodule // scc_socket_cfg

/* bench/smart_card_socket_config_test.sv */
module smart_card_socket_config_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // compare helper
    // ---------------------------------------------------------------
    `define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); end end

    localparam int          AW  = scc_pkg::SCC_AUX_PINS;
    localparam logic [31:0] RST = scc_pkg::SCC_CFG_RST;

    logic          clk_i = 1'b0;
    logic          nrst_i = 1'b0;
    logic          ce_i = 1'b1;
    logic          func_rst_n_i = 1'b1;
    logic          cfg_rd_i = 1'b0;
    logic          cfg_wr_i = 1'b0;
    logic [7:0]    cfg_addr_i = 8'h00;
    logic [3:0]    cfg_be_i = 4'h0;
    logic [31:0]   cfg_wdata_i = 32'h0000_0000;
    logic [31:0]   cfg_rdata_o;
    logic          cfg_rvalid_o;
    logic          en_o, cla_o, clb_o, pay_o, wake_o, pme_event_o;
    logic          card_present_i = 1'b0;
    logic [AW-1:0] core_aux_out_i = '0;
    logic [AW-1:0] core_aux_oe_i = '0;
    logic [AW-1:0] card_aux_pins_i = '0;
    logic [AW-1:0] core_aux_in_o, card_aux_pins_o, card_aux_pins_oe_o;
    int            n_errors = 0;
    int            num_checks = 0;
    int            cycles = 0;

    always #10 clk_i = ~clk_i;

    scc_socket_cfg #(.AUX_W(AW)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .func_rst_n_i(func_rst_n_i),
        .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
        .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_rvalid_o(cfg_rvalid_o), .sock0_enable_o(en_o),
        .sock0_volt_class_a_support_o(cla_o), .sock0_volt_class_b_support_o(clb_o),
        .sock0_payment_if_enable_o(pay_o), .sock0_insert_wake_enable_o(wake_o),
        .card_present_i(card_present_i), .pme_event_o(pme_event_o),
        .core_aux_out_i(core_aux_out_i), .core_aux_oe_i(core_aux_oe_i),
        .core_aux_in_o(core_aux_in_o), .card_aux_pins_i(card_aux_pins_i),
        .card_aux_pins_o(card_aux_pins_o), .card_aux_pins_oe_o(card_aux_pins_oe_o)
    );

    // ---------------------------------------------------------------
    // closing report
    // ---------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 5000) begin
            n_errors++;
            summarize();
        end
    end

    // ---------------------------------------------------------------
    // bus and pin tasks, all entered at a falling edge
    // ---------------------------------------------------------------
    // one write cycle, then an idle cycle so the strobe is never re-driven in one step
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_wr_i = 1'b1;
        cfg_addr_i = a;
        cfg_be_i = be;
        cfg_wdata_i = d;
        @(negedge clk_i);
        cfg_wr_i = 1'b0;
        @(negedge clk_i);
    endtask

    // read answer stands one cycle only, so it is judged in that cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        cfg_rd_i = 1'b1;
        cfg_addr_i = a;
        @(negedge clk_i);
        cfg_rd_i = 1'b0;
        `CHK(cfg_rvalid_o, 1'b1)
        `CHK(cfg_rdata_o, exp)
        @(negedge clk_i);
        `CHK(cfg_rvalid_o, 1'b0)
    endtask

    task automatic outs(input logic [31:0] v);
        `CHK(en_o, v[0])
        `CHK(wake_o, v[4])
        `CHK(pay_o, v[16])
        `CHK(cla_o, v[20])
        `CHK(clb_o, v[24])
    endtask

    // insertion, count wake pulses over ten cycles, then a removal long enough to be seen
    task automatic insert(input int exp);
        int c;
        c = 0;
        card_present_i = 1'b1;
        repeat (10) begin
            @(negedge clk_i);
            if (pme_event_o === 1'b1)
                c++;
        end
        `CHK(c, exp)
        card_present_i = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask

    task automatic aux(input logic [AW-1:0] oe, input logic [AW-1:0] o, input logic [AW-1:0] i);
        repeat (6) @(negedge clk_i);
        `CHK(card_aux_pins_oe_o, oe)
        `CHK(card_aux_pins_o, o)
        `CHK(core_aux_in_o, i)
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        rd(8'h58, RST);
        outs(RST);
        wr(8'h58, 4'hf, 32'hffff_ffff);
        rd(8'h58, 32'hf111_1011);
        outs(32'hf111_1011);
        // lane 0 only: upper lanes must keep their ones
        wr(8'h58, 4'h1, 32'h0000_0000);
        rd(8'h58, 32'hf111_1000);
        wr(8'h5c, 4'hf, 32'h0000_0000);
        rd(8'h58, 32'hf111_1000);
        rd(8'h5c, 32'h0000_0000);
        // frozen clock enable: the write is not taken
        ce_i = 1'b0;
        wr(8'h58, 4'hf, 32'h0000_0000);
        ce_i = 1'b1;
        rd(8'h58, 32'hf111_1000);
        // functional reset must leave the register alone
        func_rst_n_i = 1'b0;
        @(negedge clk_i);
        func_rst_n_i = 1'b1;
        rd(8'h58, 32'hf111_1000);
        // aux enabled but socket disabled: pins stay quiet
        core_aux_oe_i = 2'b11;
        core_aux_out_i = 2'b10;
        card_aux_pins_i = 2'b01;
        aux(2'b00, 2'b00, 2'b00);
        wr(8'h58, 4'hf, 32'h0000_1001);
        aux(2'b11, 2'b10, 2'b01);
        wr(8'h58, 4'hf, 32'h0000_0001);
        aux(2'b00, 2'b00, 2'b00);
        wr(8'h58, 4'hf, 32'h0000_0011);
        insert(1);
        insert(1);
        func_rst_n_i = 1'b0;
        insert(0);
        func_rst_n_i = 1'b1;
        wr(8'h58, 4'hf, 32'h0000_0001);
        insert(0);
        // second global reset in mid-run restores the reset value
        wr(8'h58, 4'hf, 32'h1100_0000);
        nrst_i = 1'b0;
        @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        rd(8'h58, RST);
        outs(RST);
        summarize();
    end

endmodule // smart_card_socket_config_test
